// ### dbcp_control_port.sv
// Purpose: Disk buffer control port: muxed bus cycles, wake-up and status pins.
// Assumes: pclk at 100 MHz; presetn asynchronous active low; APB slave.
// Notes: Pin inputs pass two flip-flops before use.
// Operation
// - Poll wake-up input as new command request.
// - Device clears wake-up when command finishes.
// - Master reset restores control, interrupt and bus-cycle logic; transfer fields and synchronisers keep their values.
// - Floppy interrupt only when enabled; reset disables.
// - Read strobe pulses on every bus read.
// - Write strobe pulses while write data valid.
// - One address latch pulse per instruction cycle.
// - Address valid before latch strobe falling edge.
// - Bus carries address then data per access.
// - Poll hard-disk done input for completion.
// - Drive-type high selects hard, low floppy.
// - Track zero input marks home position.
`timescale 1ns/10ps
`include "dbcp_regs.svh"
module dbcp_control_port
   import dbcp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic master_reset_in,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic command_wakeup,
   output logic wakeup_clear,
   input wire logic busy_in,
   input wire logic floppy_irq_in,
   input wire logic hard_disk_done_in,
   input wire logic drive_type_select,
   input wire logic track_zero_in,
   input wire logic buffer_full_empty_flag,
   input wire logic [7:0] muxed_bus_in,
   output logic [7:0] muxed_bus_out,
   output logic muxed_bus_oe_n,
   output logic address_latch_strobe,
   output logic read_strobe_n,
   output logic write_strobe_n
);
   localparam int STROBE_CYC = `DBCP_STROBE_CYC;
   localparam int NSYNC = 15;

   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] pin_sync;
   logic mreset;
   logic wake_s, busy_s, fd_irq_s, hd_s, type_s, trk_s, buf_s;
   logic [7:0] bus_s;
   logic wake_d, hd_d, buf_d, fd_d;
   logic [31:0] ctrl_reg;
   logic [31:0] irq_stat_reg;
   logic [31:0] irq_mask_reg;
   logic [31:0] ev_set;
   logic [7:0] rdata_reg;
   logic [7:0] xfer_addr_reg;
   logic [7:0] xfer_data_reg;
   logic xfer_write_reg;
   logic xfer_pend_reg;
   logic xfer_busy;
   logic xfer_done;
   logic [7:0] cnt_reg;
   logic apb_wr;
   logic apb_rd;
   logic hit;
   dbcp_bus_state_e state_reg;

   assign pin_raw = {master_reset_in, command_wakeup, busy_in, floppy_irq_in,
      hard_disk_done_in, drive_type_select, track_zero_in, muxed_bus_in};

   dbcp_sync #(
      .WIDTH(NSYNC)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pin_raw),
      .sync_out(pin_sync)
   );

   dbcp_sync #(
      .WIDTH(1)
   ) u_sync_buf (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(buffer_full_empty_flag),
      .sync_out(buf_s)
   );

   assign mreset = pin_sync[14];
   assign wake_s = pin_sync[13];
   assign busy_s = pin_sync[12];
   assign fd_irq_s = pin_sync[11];
   assign hd_s = pin_sync[10];
   assign type_s = pin_sync[9];
   assign trk_s = pin_sync[8];
   assign bus_s = pin_sync[7:0];

   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && penable && !pwrite;
   assign hit = (paddr == `DBCP_CTRL_OFS) || (paddr == `DBCP_STAT_OFS) ||
      (paddr == `DBCP_IRQ_STAT_OFS) || (paddr == `DBCP_IRQ_MASK_OFS) ||
      (paddr == `DBCP_XFER_OFS) || (paddr == `DBCP_RDATA_OFS);
   assign xfer_busy = (state_reg != DBCP_IDLE) || xfer_pend_reg;

   // Edge history of synchronised inputs for event detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_d <= 1'b0;
         hd_d <= 1'b0;
         buf_d <= 1'b0;
         fd_d <= 1'b0;
      end else begin
         wake_d <= wake_s;
         hd_d <= hd_s;
         buf_d <= buf_s;
         fd_d <= fd_irq_s;
      end
   end

   always_comb begin
      ev_set = '0;
      ev_set[`DBCP_EV_WAKEUP] = wake_s && !wake_d;
      ev_set[`DBCP_EV_HD_DONE] = hd_s && !hd_d;
      ev_set[`DBCP_EV_FLOPPY] = fd_irq_s && !fd_d && ctrl_reg[`DBCP_CTRL_IRQ_EN];
      ev_set[`DBCP_EV_BUF] = buf_s && !buf_d;
      ev_set[`DBCP_EV_XFER] = xfer_done;
   end

   // Control register; master reset returns it to the disabled state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `DBCP_CTRL_RESET;
      end else if (mreset) begin
         ctrl_reg <= `DBCP_CTRL_RESET;
      end else if (apb_wr && paddr == `DBCP_CTRL_OFS) begin
         ctrl_reg <= {30'h0, pwdata[`DBCP_CTRL_DONE], pwdata[`DBCP_CTRL_IRQ_EN]};
      end
   end

   // Wake-up clear pulse is held while software signals command completion and the synchronised wake-up input is still high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wakeup_clear <= 1'b0;
      end else begin
         wakeup_clear <= ctrl_reg[`DBCP_CTRL_DONE] && wake_s && !mreset;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= '0;
      end else if (mreset) begin
         irq_stat_reg <= '0;
      end else if (apb_wr && paddr == `DBCP_IRQ_STAT_OFS) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata) | ev_set;
      end else begin
         irq_stat_reg <= irq_stat_reg | ev_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= '0;
      end else if (mreset) begin
         irq_mask_reg <= '0;
      end else if (apb_wr && paddr == `DBCP_IRQ_MASK_OFS) begin
         irq_mask_reg <= pwdata & 32'h0000_001F;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Transfer request: address in bits 7:0, data in 15:8, direction in bit 16.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_pend_reg <= 1'b0;
         xfer_addr_reg <= 8'h00;
         xfer_data_reg <= 8'h00;
         xfer_write_reg <= 1'b0;
      end else if (mreset) begin
         xfer_pend_reg <= 1'b0;
      end else if (apb_wr && paddr == `DBCP_XFER_OFS && !xfer_busy) begin
         xfer_pend_reg <= 1'b1;
         xfer_addr_reg <= pwdata[7:0];
         xfer_data_reg <= pwdata[15:8];
         xfer_write_reg <= pwdata[`DBCP_XFER_WRITE];
      end else if (state_reg == DBCP_IDLE) begin
         xfer_pend_reg <= 1'b0;
      end
   end

   // External cycle: address, latch pulse, turn, strobe, end.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= DBCP_IDLE;
         cnt_reg <= 8'h00;
         address_latch_strobe <= 1'b0;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         muxed_bus_out <= 8'h00;
         muxed_bus_oe_n <= 1'b1;
         rdata_reg <= 8'h00;
         xfer_done <= 1'b0;
      end else if (mreset) begin
         state_reg <= DBCP_IDLE;
         cnt_reg <= 8'h00;
         address_latch_strobe <= 1'b0;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         muxed_bus_oe_n <= 1'b1;
         muxed_bus_out <= 8'h00;
         rdata_reg <= 8'h00;
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= 1'b0;
         case (state_reg)
            DBCP_IDLE: begin
               if (xfer_pend_reg) begin
                  muxed_bus_out <= xfer_addr_reg;
                  muxed_bus_oe_n <= 1'b0;
                  state_reg <= DBCP_ADDR;
               end
            end
            DBCP_ADDR: begin
               address_latch_strobe <= 1'b1;
               state_reg <= DBCP_LATCH;
            end
            DBCP_LATCH: begin
               address_latch_strobe <= 1'b0;
               state_reg <= DBCP_TURN;
            end
            DBCP_TURN: begin
               cnt_reg <= 8'(STROBE_CYC - 1);
               if (xfer_write_reg) begin
                  muxed_bus_out <= xfer_data_reg;
                  state_reg <= DBCP_STROBE;
               end else begin
                  muxed_bus_oe_n <= 1'b1;
                  state_reg <= DBCP_STROBE;
               end
            end
            DBCP_STROBE: begin
               if (xfer_write_reg) begin
                  write_strobe_n <= 1'b0;
               end else begin
                  read_strobe_n <= 1'b0;
               end
               if (!read_strobe_n || !write_strobe_n) begin
                  if (cnt_reg == 8'h00) begin
                     state_reg <= DBCP_END;
                     read_strobe_n <= 1'b1;
                     write_strobe_n <= 1'b1;
                     if (!xfer_write_reg) begin
                        rdata_reg <= bus_s;
                     end
                  end else begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end
               end
            end
            DBCP_END: begin
               muxed_bus_oe_n <= 1'b1;
               xfer_done <= 1'b1;
               state_reg <= DBCP_IDLE;
            end
            default: begin
               state_reg <= DBCP_IDLE;
            end
         endcase
      end
   end

   // APB answers in the access cycle; unmapped addresses return an error.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit;
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            if (paddr == `DBCP_CTRL_OFS) begin
               prdata <= ctrl_reg;
            end else if (paddr == `DBCP_STAT_OFS) begin
               prdata <= {26'h0, busy_s, buf_s, trk_s, type_s, hd_s, wake_s};
            end else if (paddr == `DBCP_IRQ_STAT_OFS) begin
               prdata <= irq_stat_reg;
            end else if (paddr == `DBCP_IRQ_MASK_OFS) begin
               prdata <= irq_mask_reg;
            end else if (paddr == `DBCP_XFER_OFS) begin
               // Busy sits in bit 23; the request fields read back where they were written.
               prdata <= {8'h00, xfer_busy, 6'h00, xfer_write_reg, xfer_data_reg, xfer_addr_reg};
            end else if (paddr == `DBCP_RDATA_OFS) begin
               prdata <= {24'h00_0000, rdata_reg};
            end
         end
      end
   end

   logic unused_apb;
   assign unused_apb = apb_rd;
endmodule // dbcp_control_port

// ### dbcp_control_port_chk.sv
// Purpose: Pin and bus timing checker for the control port.
// Assumes: Sees only top module ports.
// Notes: Master reset masks the timing checks.
`timescale 1ns/10ps
module dbcp_control_port_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic master_reset_in,
   input wire logic irq,
   input wire logic command_wakeup,
   input wire logic wakeup_clear,
   input wire logic [7:0] muxed_bus_out,
   input wire logic muxed_bus_oe_n,
   input wire logic address_latch_strobe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn || master_reset_in);
   a_latch_single_pulse: assert property (address_latch_strobe |=> !address_latch_strobe)
      else $error("latch strobe too long");
   a_addr_before_latch: assert property ($rose(address_latch_strobe) |->
      !muxed_bus_oe_n && !$past(muxed_bus_oe_n) ##1 (!muxed_bus_oe_n && $stable(muxed_bus_out)))
      else $error("address not held across latch");
   a_read_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n[*3] ##1 read_strobe_n)
      else $error("read strobe width wrong");
   a_write_width: assert property ($fell(write_strobe_n) |-> !write_strobe_n[*3] ##1 write_strobe_n)
      else $error("write strobe width wrong");
   a_write_data_held: assert property (!write_strobe_n |-> !muxed_bus_oe_n && $stable(muxed_bus_out))
      else $error("write data not valid under strobe");
   a_read_bus_released: assert property (!read_strobe_n |-> muxed_bus_oe_n && write_strobe_n)
      else $error("bus driven during read");
   a_strobe_after_latch: assert property ($fell(read_strobe_n) || $fell(write_strobe_n) |->
      $past(address_latch_strobe, 3))
      else $error("data phase not after address phase");
   a_clear_ends: assert property ($fell(command_wakeup) |-> ##[1:5] !wakeup_clear)
      else $error("wake-up clear held too long");
   a_reset_idle: assert property (@(posedge pclk) disable iff (!presetn) master_reset_in[*6] |->
      read_strobe_n && write_strobe_n && muxed_bus_oe_n && !irq && !wakeup_clear)
      else $error("master reset left outputs active");
   c_read: cover property ($fell(read_strobe_n));
   c_write: cover property ($fell(write_strobe_n));
   c_irq: cover property ($rose(irq));
   c_clear: cover property ($rose(wakeup_clear));
endmodule // dbcp_control_port_chk

bind dbcp_control_port dbcp_control_port_chk dbcp_control_port_chk_inst (.pclk, .presetn,
   .master_reset_in, .irq, .command_wakeup, .wakeup_clear, .muxed_bus_out, .muxed_bus_oe_n,
   .address_latch_strobe, .read_strobe_n, .write_strobe_n);

// ### dbcp_control_port_tb_top.sv
// Purpose: Self-checking bench for the control port.
// Assumes: APB master tasks; the bench plays the board logic.
// Notes: Pin inputs are synchronised, so waits follow each pin change.
`timescale 1ns/10ps
`include "dbcp_regs.svh"
module dbcp_control_port_tb_top;
   logic pclk = '0, presetn = '0, master_reset_in = '0, psel = '0, penable = '0, pwrite = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_v;
   logic pready, pslverr, irq, wakeup_clear, err_v, muxed_bus_oe_n;
   logic command_wakeup = '0, busy_in = '0, floppy_irq_in = '0, hard_disk_done_in = '0;
   logic drive_type_select = '0, track_zero_in = '0, buffer_full_empty_flag = '0;
   logic [7:0] muxed_bus_in, muxed_bus_out, rd_byte = '0, addr_seen, data_seen;
   logic address_latch_strobe, read_strobe_n, write_strobe_n;
   int miscompares = 0, tests_run = 0, cycles = 0;
   dbcp_control_port dbcp_control_port_inst (.pclk, .presetn, .master_reset_in, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .command_wakeup,
      .wakeup_clear, .busy_in, .floppy_irq_in, .hard_disk_done_in, .drive_type_select,
      .track_zero_in, .buffer_full_empty_flag, .muxed_bus_in, .muxed_bus_out, .muxed_bus_oe_n,
      .address_latch_strobe, .read_strobe_n, .write_strobe_n);
   dbcp_port_dev dbcp_port_dev_inst (.pclk, .muxed_bus_out, .muxed_bus_oe_n,
      .address_latch_strobe, .read_strobe_n, .write_strobe_n, .rd_byte, .muxed_bus_in,
      .addr_seen, .data_seen);
   always #5 pclk = ~pclk;
   task automatic end_of_test;
      $display("Checks run %0d, miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test;
      end
   end
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= '1;
      penable <= '0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= '1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd_v = prdata;
      err_v = pslverr;
      psel <= '0;
      penable <= '0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'h1, d);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(a, 1'h0, 32'h0);
   endtask
   // A second request while busy must be ignored, so the latch still shows the first.
   task automatic xfer(input logic [31:0] cmd);
      wr(`DBCP_XFER_OFS, cmd);
      wr(`DBCP_XFER_OFS, 32'h0001_FF77);
      rd(`DBCP_XFER_OFS);
      while (rd_v[23] !== 1'h0) rd(`DBCP_XFER_OFS);
      chk("xfer_reg", rd_v & 32'h0001_FFFF, cmd & 32'h0001_FFFF);
      chk("addr", 32'(addr_seen), 32'(cmd[7:0]));
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= '1;
      @(posedge pclk);
      chk("idle", 32'({read_strobe_n, write_strobe_n, muxed_bus_oe_n, irq}), 32'hE);
      rd(`DBCP_CTRL_OFS);
      chk("ctrl", rd_v, 32'h0);
      chk("ctrl_err", 32'(err_v), 32'h0);
      {drive_type_select, track_zero_in, busy_in} <= 3'h7;
      repeat (4) @(posedge pclk);
      rd(`DBCP_STAT_OFS);
      chk("stat1", rd_v & 32'h3F, 32'h2C);
      {drive_type_select, track_zero_in, busy_in} <= 3'h0;
      {hard_disk_done_in, buffer_full_empty_flag} <= 2'h3;
      repeat (4) @(posedge pclk);
      rd(`DBCP_STAT_OFS);
      chk("stat2", rd_v & 32'h3F, 32'h12);
      rd(`DBCP_IRQ_STAT_OFS);
      chk("events", rd_v & 32'h1F, 32'h0A);
      wr(`DBCP_IRQ_STAT_OFS, 32'h1F);
      rd(12'h020);
      chk("unmapped", 32'(err_v), 32'h1);
      xfer(32'h0001_C35A);
      chk("wdata", 32'(data_seen), 32'hC3);
      rd_byte <= 8'hA5;
      xfer(32'h0000_0033);
      rd(`DBCP_RDATA_OFS);
      chk("rdata", rd_v & 32'hFF, 32'hA5);
      rd(`DBCP_IRQ_STAT_OFS);
      chk("xfer_ev", rd_v & 32'h1F, 32'h10);
      chk("masked", 32'(irq), 32'h0);
      wr(`DBCP_IRQ_MASK_OFS, 32'h10);
      repeat (2) @(posedge pclk);
      chk("irq_on", 32'(irq), 32'h1);
      wr(`DBCP_IRQ_STAT_OFS, 32'h10);
      repeat (2) @(posedge pclk);
      chk("irq_off", 32'(irq), 32'h0);
      wr(`DBCP_IRQ_MASK_OFS, 32'h04);
      for (int i = 0; i < 2; i++) begin
         wr(`DBCP_CTRL_OFS, 32'(i));
         floppy_irq_in <= '1;
         repeat (7) @(posedge pclk);
         chk("fd_irq", 32'(irq), 32'(i));
         floppy_irq_in <= '0;
         rd(`DBCP_IRQ_STAT_OFS);
         chk("fd_ev", rd_v & 32'h4, 32'(i * 4));
         wr(`DBCP_IRQ_STAT_OFS, 32'h4);
      end
      wr(`DBCP_IRQ_MASK_OFS, 32'h01);
      {command_wakeup, busy_in} <= 2'h3;
      repeat (7) @(posedge pclk);
      chk("wake_irq", 32'(irq), 32'h1);
      wr(`DBCP_CTRL_OFS, 32'h2);
      repeat (4) @(posedge pclk);
      chk("clear", 32'(wakeup_clear), 32'h1);
      command_wakeup <= '0;
      repeat (7) @(posedge pclk);
      chk("clear_end", 32'(wakeup_clear), 32'h0);
      master_reset_in <= '1;
      repeat (6) @(posedge pclk);
      master_reset_in <= '0;
      repeat (4) @(posedge pclk);
      rd(`DBCP_CTRL_OFS);
      chk("mr_ctrl", rd_v, 32'h0);
      rd(`DBCP_IRQ_MASK_OFS);
      chk("mr_mask", rd_v, 32'h0);
      end_of_test;
   end
endmodule // dbcp_control_port_tb_top

// ### dbcp_pkg.sv
// Purpose: Types shared by the control port design.
// Assumes: Nothing beyond the register header.
// Notes: State enumeration for the external bus cycle.
package dbcp_pkg;
   typedef enum logic [2:0] {
      DBCP_IDLE,
      DBCP_ADDR,
      DBCP_LATCH,
      DBCP_TURN,
      DBCP_STROBE,
      DBCP_END
   } dbcp_bus_state_e;
endpackage

// ### dbcp_port_dev.sv
// Purpose: Port device and address latch beyond the muxed bus.
// Assumes: The design drives the bus while its enable is low.
// Notes: A released bus shows a pattern that flips every cycle.
`timescale 1ns/10ps
module dbcp_port_dev (
   input wire logic pclk,
   input wire logic [7:0] muxed_bus_out,
   input wire logic muxed_bus_oe_n,
   input wire logic address_latch_strobe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [7:0] rd_byte,
   output logic [7:0] muxed_bus_in,
   output logic [7:0] addr_seen,
   output logic [7:0] data_seen
);
   logic [7:0] last_level = '0;
   int hold = 0;
   // The byte stays on the bus a few cycles past the strobe for the synchroniser.
   always @(posedge pclk) hold <= !read_strobe_n ? 3 : (hold > 0 ? hold - 1 : 0);
   always @(posedge pclk) last_level <= muxed_bus_in;
   always_comb begin
      if (!muxed_bus_oe_n)
         muxed_bus_in = muxed_bus_out;
      else if (!read_strobe_n || hold > 0)
         muxed_bus_in = rd_byte;
      else
         muxed_bus_in = ~last_level;
   end
   always @(negedge address_latch_strobe) addr_seen <= muxed_bus_in;
   always @(posedge write_strobe_n) data_seen <= muxed_bus_in;
endmodule // dbcp_port_dev

// ### dbcp_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Included by the control port top module.
`ifndef DBCP_REGS_SVH
`define DBCP_REGS_SVH

`define DBCP_CTRL_OFS 12'h000
`define DBCP_STAT_OFS 12'h004
`define DBCP_IRQ_STAT_OFS 12'h008
`define DBCP_IRQ_MASK_OFS 12'h00C
`define DBCP_XFER_OFS 12'h010
`define DBCP_RDATA_OFS 12'h014

`define DBCP_CTRL_IRQ_EN 0
`define DBCP_CTRL_DONE 1
`define DBCP_CTRL_RESET 32'h0000_0000

`define DBCP_ST_WAKEUP 0
`define DBCP_ST_HD_DONE 1
`define DBCP_ST_HD_SEL 2
`define DBCP_ST_TRK0 3
`define DBCP_ST_BUF 4
`define DBCP_ST_BUSY 5

`define DBCP_EV_WAKEUP 0
`define DBCP_EV_HD_DONE 1
`define DBCP_EV_FLOPPY 2
`define DBCP_EV_BUF 3
`define DBCP_EV_XFER 4
`define DBCP_EV_W 5

`define DBCP_XFER_WRITE 16
`define DBCP_STROBE_NS 30
`define DBCP_CLK_NS 10
`define DBCP_STROBE_CYC ((`DBCP_STROBE_NS + `DBCP_CLK_NS - 1) / `DBCP_CLK_NS)

`endif

// ### dbcp_sync.sv
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes: The first stage is read only by the second.
`timescale 1ns/10ps
module dbcp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // dbcp_sync
